// >>> verilog/timer16.sv
// Sixteen-bit timer/counter with prescaler, wide access mode and AXI4-Lite registers.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module timer16
   import timer16_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic sec_osc_in_pin,
   input wire logic sleep_mode,
   output logic sec_osc_run,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic aw_held_ff;
   logic w_held_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [7:0] w_byte_ff;
   logic w_strb0_ff;
   wr_req_t wr_req;
   logic wr_fire;
   logic rd_fire;
   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic wr_osc;
   logic wr_osc2;
   logic wr_stat;
   logic wr_mask;
   logic rd_low_wide;
   logic [DATA_W-1:0] rd_word;
   logic rd_hit;
   ctrl_t ctrl_ff;
   logic [SCS_W-1:0] scs_ff;
   logic osc_go_ff;
   logic [15:0] count_ff;
   logic [7:0] high_buf_ff;
   logic stat_ff;
   logic mask_ff;
   logic nxt_stat;
   logic ext_s;
   logic ext_d1_ff;
   logic ext_d2_ff;
   logic async_edge;
   logic sync_edge;
   logic src_tick;
   logic run_ok;
   logic pre_clear;
   logic inc;
   logic cnt_write;
   logic ovf;

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data are taken in either order.

   assign wr_fire = aw_held_ff && w_held_ff && !bvalid;
   assign wr_req = '{addr: aw_addr_ff, data: w_byte_ff, strb0: w_strb0_ff};

   // Address capture; ready drops once taken and returns after the response.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awready <= 1'b1;
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held_ff <= 1'b1;
         aw_addr_ff <= awaddr;
      end else if (wr_fire) begin
         aw_held_ff <= 1'b0;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
      end
   end

   // Data capture; all registers are one byte wide so only lane 0 matters.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wready <= 1'b1;
         w_held_ff <= 1'b0;
         w_byte_ff <= BYTE_RESET;
         w_strb0_ff <= 1'b0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held_ff <= 1'b1;
         w_byte_ff <= wdata[7:0];
         w_strb0_ff <= wstrb[0];
      end else if (wr_fire) begin
         w_held_ff <= 1'b0;
      end else if (bvalid && bready) begin
         wready <= 1'b1;
      end
   end

   // Write response one cycle after both halves are held.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= (wr_ctrl || wr_low || wr_high || wr_osc || wr_osc2 || wr_stat || wr_mask ||
                   !wr_req.strb0) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Write strobes; a write with byte lane 0 off stores nothing.
   assign wr_ctrl = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_CONTROL);
   assign wr_low = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_COUNT_LOW);
   assign wr_high = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_COUNT_HIGH);
   assign wr_osc = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_OSC_CONTROL);
   assign wr_osc2 = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_OSC_CONTROL_TWO);
   assign wr_stat = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_IRQ_STATUS);
   assign wr_mask = wr_fire && wr_req.strb0 && is_ofs(wr_req.addr, OFS_IRQ_MASK);

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel.

   assign rd_fire = arvalid && arready;

   // high byte via buffer.
   // Read multiplexer; in wide mode the high byte comes only from the buffer.
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      if (is_ofs(araddr, OFS_CONTROL)) begin
         rd_word[CTRL_W-1:0] = ctrl_ff;
      end else if (is_ofs(araddr, OFS_COUNT_LOW)) begin
         rd_word[7:0] = count_ff[7:0];
      end else if (is_ofs(araddr, OFS_COUNT_HIGH)) begin
         rd_word[7:0] = ctrl_ff.wide_access_enable ? high_buf_ff : count_ff[15:8];
      end else if (is_ofs(araddr, OFS_OSC_CONTROL)) begin
         rd_word[SCS_W-1:0] = scs_ff;
      end else if (is_ofs(araddr, OFS_OSC_CONTROL_TWO)) begin
         rd_word[OSC2_GO_BIT] = osc_go_ff;
         rd_word[OSC2_RUN_BIT] = sec_osc_run;
      end else if (is_ofs(araddr, OFS_IRQ_STATUS)) begin
         rd_word[IRQ_OVF_BIT] = stat_ff;
      end else if (is_ofs(araddr, OFS_IRQ_MASK)) begin
         rd_word[IRQ_OVF_BIT] = mask_ff;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // coherent byte reads.
   // The count lives in this clock domain, so a read never sees a half-updated value.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (rd_fire) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_word;
         rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control and oscillator registers.

   // Software writable configuration.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_ff <= ctrl_t'(7'h00);
         scs_ff <= SCS_RESET;
         osc_go_ff <= 1'b0;
         mask_ff <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= ctrl_t'(wr_req.data[CTRL_W-1:0]);
         end
         if (wr_osc) begin
            scs_ff <= wr_req.data[SCS_W-1:0];
         end
         if (wr_osc2) begin
            osc_go_ff <= wr_req.data[OSC2_GO_BIT];
         end
         if (wr_mask) begin
            mask_ff <= wr_req.data[IRQ_OVF_BIT];
         end
      end
   end

   // sleep does not stop it.
   // Sleep is deliberately absent here so a sleeping core keeps its timebase.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sec_osc_run <= 1'b0;
      end else begin
         sec_osc_run <= ctrl_ff.sec_osc_enable || osc_go_ff || (scs_ff == SCS_SECONDARY);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // External count input and count source selection.

   sync2 #(
      .W(1)
   ) u_ext_sync (
      .clk(clk),
      .rst(rst),
      .d(sec_osc_in_pin),
      .q(ext_s)
   );

   // Two further delay stages give the early and the late edge detector.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_d1_ff <= 1'b0;
         ext_d2_ff <= 1'b0;
      end else begin
         ext_d1_ff <= ext_s;
         ext_d2_ff <= ext_d1_ff;
      end
   end

   assign async_edge = ext_s && !ext_d1_ff;
   assign sync_edge = ext_d1_ff && !ext_d2_ff;

   // one increment may slip.
   // The two detectors see the same edge one cycle apart, so changing the mode
   // can drop an edge or count one twice; this is accepted, not corrected.
   assign src_tick = ctrl_ff.ext_clock_sel ? (ctrl_ff.sync_disable ? async_edge : sync_edge)
                                           : 1'b1;

   // keep counting in sleep.
   // Only the asynchronous external mode runs while the core clocks are stopped.
   assign run_ok = ctrl_ff.timer_on &&
                   (!sleep_mode || (ctrl_ff.sync_disable && ctrl_ff.ext_clock_sel));

   // wide mode clears on low only.
   assign pre_clear = wr_low || (wr_high && !ctrl_ff.wide_access_enable);

   count_prescaler u_prescaler (
      .clk(clk),
      .rst(rst),
      .tick(run_ok && src_tick),
      .clear(pre_clear),
      .sel(ctrl_ff.prescale_select),
      .out_tick(inc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Sixteen-bit count and the high byte buffer.

   // A write that reaches the live count wins over an increment in the same cycle.
   assign cnt_write = wr_low || (wr_high && !ctrl_ff.wide_access_enable);
   assign rd_low_wide = rd_fire && ctrl_ff.wide_access_enable && is_ofs(araddr, OFS_COUNT_LOW);

   // load both bytes at once.
   // The live count register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_ff <= COUNT_RESET;
      end else if (wr_low && ctrl_ff.wide_access_enable) begin
         count_ff <= {high_buf_ff, wr_req.data};
      end else if (wr_low) begin
         count_ff <= {count_ff[15:8], wr_req.data};
      end else if (wr_high && !ctrl_ff.wide_access_enable) begin
         count_ff <= {wr_req.data, count_ff[7:0]};
      end else if (inc) begin
         count_ff <= count_ff + COUNT_ONE;
      end
   end

   // snapshot on low read.
   // The buffer takes software's high byte, or the live high byte on a low read.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_buf_ff <= BYTE_RESET;
      end else if (wr_high && ctrl_ff.wide_access_enable) begin
         high_buf_ff <= wr_req.data;
      end else if (rd_low_wide) begin
         high_buf_ff <= count_ff[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overflow flag and interrupt.

   assign ovf = inc && !cnt_write && (count_ff == COUNT_MAX);

   // A new overflow beats a write-one clear in the same cycle.
   always_comb begin
      nxt_stat = stat_ff;
      if (wr_stat && wr_req.data[IRQ_OVF_BIT]) begin
         nxt_stat = 1'b0;
      end
      if (ovf) begin
         nxt_stat = 1'b1;
      end
   end

   // Sticky status and the level interrupt, which also serves as the wake request.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_ff <= 1'b0;
         irq <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq <= stat_ff && mask_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   property p_clear_plain;
      @(posedge clk) disable iff (rst)
      ((wr_low || wr_high) && !ctrl_ff.wide_access_enable) |=> (u_prescaler.pre_ff == PRE_RESET);
   endproperty
   a_clear_plain: assert property (p_clear_plain)
      else $error("prescaler not cleared by a count byte write");

   property p_wide_high_keeps;
      @(posedge clk) disable iff (rst)
      (wr_high && ctrl_ff.wide_access_enable) |-> !pre_clear ##1 (count_ff[15:8] ==
         $past(count_ff[15:8]) || $past(inc));
   endproperty
   a_wide_high_keeps: assert property (p_wide_high_keeps)
      else $error("wide high write touched prescaler or live high byte");

   property p_osc_enable;
      @(posedge clk) disable iff (rst)
      (ctrl_ff.sec_osc_enable || osc_go_ff || scs_ff == SCS_SECONDARY) [*2] |-> sec_osc_run;
   endproperty
   a_osc_enable: assert property (p_osc_enable)
      else $error("secondary oscillator not enabled");

   property p_osc_sleep;
      @(posedge clk) disable iff (rst)
      (sleep_mode && (ctrl_ff.sec_osc_enable || osc_go_ff || scs_ff == SCS_SECONDARY)) |=>
         sec_osc_run;
   endproperty
   a_osc_sleep: assert property (p_osc_sleep)
      else $error("secondary oscillator stopped during sleep");

   property p_snapshot;
      @(posedge clk) disable iff (rst)
      rd_low_wide && !wr_high |=> (high_buf_ff == $past(count_ff[15:8]));
   endproperty
   a_snapshot: assert property (p_snapshot)
      else $error("low byte read did not snapshot the high byte");

   property p_wide_load;
      @(posedge clk) disable iff (rst)
      (wr_low && ctrl_ff.wide_access_enable) |=>
         (count_ff == {$past(high_buf_ff), $past(wr_req.data)});
   endproperty
   a_wide_load: assert property (p_wide_load)
      else $error("wide low write did not load both bytes");

   property p_buffer_read;
      @(posedge clk) disable iff (rst)
      (rd_fire && ctrl_ff.wide_access_enable && is_ofs(araddr, OFS_COUNT_HIGH)) |=>
         (rdata[7:0] == $past(high_buf_ff));
   endproperty
   a_buffer_read: assert property (p_buffer_read)
      else $error("wide high read bypassed the buffer");

   property p_sleep_async;
      @(posedge clk) disable iff (rst)
      (sleep_mode && ctrl_ff.timer_on && ctrl_ff.ext_clock_sel && ctrl_ff.sync_disable &&
       async_edge && ctrl_ff.prescale_select == 2'b00 && !cnt_write) |=>
         (count_ff == $past(count_ff) + COUNT_ONE);
   endproperty
   a_sleep_async: assert property (p_sleep_async)
      else $error("asynchronous count stalled in sleep");

   property p_wrap_flag;
      @(posedge clk) disable iff (rst)
      ovf |=> (stat_ff && count_ff == COUNT_RESET) ##1 (irq == $past(mask_ff));
   endproperty
   a_wrap_flag: assert property (p_wrap_flag)
      else $error("wrap did not set the overflow flag");

endmodule

// >>> inc/timer16_pkg.sv
// Shared constants, register map, field types and helpers of the sixteen-bit timer/counter.
package timer16_pkg;

   // Bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte addresses, one aligned word each.
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_COUNT_LOW = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_OSC_CONTROL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_OSC_CONTROL_TWO = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

   // Field positions and widths.
   localparam int CTRL_W = 7;
   localparam int SCS_W = 2;
   localparam int OSC2_GO_BIT = 0;
   localparam int OSC2_RUN_BIT = 1;
   localparam int IRQ_OVF_BIT = 0;

   // Encodings and reset values.
   localparam logic [1:0] SCS_SECONDARY = 2'b01;
   localparam logic [1:0] SCS_RESET = 2'b00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] PRE_RESET = 3'h0;

   // Timer control register, bit 6 down to bit 0.
   typedef struct packed {
      logic ext_clock_sel;
      logic [1:0] prescale_select;
      logic sec_osc_enable;
      logic sync_disable;
      logic wide_access_enable;
      logic timer_on;
   } ctrl_t;

   // A write request once both address and data have been taken.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
      logic strb0;
   } wr_req_t;

   // Terminal count mask of the prescaler for a divide select.
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      case (sel)
         2'b00: div_mask = 3'h0;
         2'b01: div_mask = 3'h1;
         2'b10: div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction

   // Word decode that ignores the byte lane bits of the address.
   function automatic logic is_ofs(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
      is_ofs = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
   endfunction

endpackage

// >>> verilog/sync2.sv
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_ff;

   // The first stage feeds only the second stage, never any logic.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end

endmodule

// >>> verilog/count_prescaler.sv
// Hidden divide-by-1/2/4/8 prescaler in front of the sixteen-bit count.
`timescale 1ns/1ps
module count_prescaler
   import timer16_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic clear,
   input wire logic [1:0] sel,
   output logic out_tick
);

   logic [2:0] pre_ff;

   // divide the ticks.
   // A pass is given on the tick that finds the counter at its mask.
   assign out_tick = tick && ((pre_ff & div_mask(sel)) == div_mask(sel));

   // no software path.
   // The counter has no bus port; only a clear from a count write reaches it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_ff <= PRE_RESET;
      end else if (clear) begin
         pre_ff <= PRE_RESET;
      end else if (out_tick) begin
         pre_ff <= PRE_RESET;
      end else if (tick) begin
         pre_ff <= pre_ff + 3'h1;
      end
   end

   // Full count with steady select always passes the tick on.
   property p_div_pass;
      @(posedge clk) disable iff (rst)
      (tick && !clear && pre_ff == div_mask(sel)) |-> out_tick;
   endproperty
   a_div_pass: assert property (p_div_pass)
      else $error("prescaler withheld a tick at terminal count");

   // Every pass restarts the division from zero.
   property p_div_restart;
      @(posedge clk) disable iff (rst)
      out_tick |=> (pre_ff == PRE_RESET);
   endproperty
   a_div_restart: assert property (p_div_restart)
      else $error("prescaler did not restart after a pass");

endmodule

// >>> test/count_src.sv
// External count clock source that drives the count input pin.
`timescale 1ns/1ps
module count_src #(
   parameter int HALF = 4
) (
   input wire logic clk,
   output logic pin
);
   // The source stands still and low between bursts.
   initial pin = 1'b0;
   // Whole pulses only, then a settle time so sync and prescale stages drain.
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++) begin
         pin <= 1'b1;
         repeat (HALF) @(posedge clk);
         pin <= 1'b0;
         repeat (HALF) @(posedge clk);
      end
      repeat (HALF) @(posedge clk);
   endtask
endmodule

// >>> test/tb.sv
// Self-checking testbench of the sixteen-bit timer/counter.
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %0t %s", $time, m); end end
module tb import timer16_pkg::*;;
   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
   logic sleep_mode, sec_osc_run, irq, pin, bready, rready;
   logic [3:0] wstrb;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata, data;
   logic [1:0] bresp, rresp, resp;
   int n_mismatch = 0;
   int n_compared = 0;

   // Every bus input is driven by the bench; the two oscillator control registers are never read back.
   timer16 dut_u (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .sec_osc_in_pin(pin), .sleep_mode(sleep_mode), .sec_osc_run(sec_osc_run), .irq(irq));
   count_src src_u (.clk(clk), .pin(pin));

   ////////////////////////////////////////
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic timeout();
      n_mismatch++;
      $display("MISMATCH %0t bus wait ran out", $time);
      end_of_test();
   endtask
   // Address and data go out together; each drops once taken.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      rready <= 1'b0;
      for (int i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            return;
         end
      end
      timeout();
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      bready <= 1'b0;
      for (int i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            data = rdata;
            resp = rresp;
            return;
         end
      end
      timeout();
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string m);
      rd(a);
      `CHK(data, {24'h0, e}, m)
      `CHK(resp, RESP_OKAY, m)
   endtask
   // Control word with the pin as count source and the oscillator kept on.
   function automatic logic [7:0] ctl(input logic [1:0] p, input logic w, input logic s);
      ctrl_t c;
      c = '{1'b1, p, 1'b1, s, w, 1'b1};
      return {1'b0, c};
   endfunction
   task automatic setcount(input logic [7:0] h, input logic [7:0] l);
      wr(OFS_COUNT_HIGH, h);
      wr(OFS_COUNT_LOW, l);
   endtask

   ////////////////////////////////////////
   task automatic t_osc();
      logic [ADDR_W-1:0] a [3] = '{OFS_CONTROL, OFS_OSC_CONTROL_TWO, OFS_OSC_CONTROL};
      logic [7:0] v [3] = '{8'h08, 8'h01, {6'h0, SCS_SECONDARY}};
      rchk(OFS_CONTROL, 8'h00, "control reset");
      `CHK(irq, 1'b0, "irq reset")
      sleep_mode <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         wr(a[i], v[i]);
         repeat (2) @(posedge clk);
         `CHK(sec_osc_run, 1'b1, "osc on")
         wr(a[i], 8'h00);
         repeat (2) @(posedge clk);
         `CHK(sec_osc_run, 1'b0, "osc off")
      end
      sleep_mode <= 1'b0;
      $display("test osc finished");
   endtask
   task automatic t_presc();
      // Oscillator first, a settling pause, only then the timer.
      wr(OFS_CONTROL, 8'h08);
      repeat (20) @(posedge clk);
      for (int p = 0; p < 4; p++) begin
         wr(OFS_CONTROL, ctl(p[1:0], 1'b0, 1'b0));
         setcount(8'h00, 8'h00);
         src_u.pulse(16);
         rchk(OFS_COUNT_LOW, 8'(16 >> p), "divided count");
      end
      $display("test presc finished");
   endtask
   // Six pulses are left in the divide-by-8 stage when the high byte is written.
   task automatic t_clear();
      wr(OFS_CONTROL, ctl(2'd3, 1'b0, 1'b0));
      setcount(8'h00, 8'h00);
      src_u.pulse(6);
      wr(OFS_COUNT_HIGH, 8'h00);
      src_u.pulse(4);
      rchk(OFS_COUNT_LOW, 8'h00, "high write clears");
      wr(OFS_CONTROL, ctl(2'd3, 1'b1, 1'b0));
      wr(OFS_COUNT_LOW, 8'h00);
      src_u.pulse(6);
      wr(OFS_COUNT_HIGH, 8'h55);
      src_u.pulse(4);
      rchk(OFS_COUNT_LOW, 8'h01, "wide high write keeps prescale");
      rchk(OFS_COUNT_HIGH, 8'h00, "live high untouched");
      setcount(8'h55, 8'h22);
      rchk(OFS_COUNT_LOW, 8'h22, "joint load low");
      rchk(OFS_COUNT_HIGH, 8'h55, "joint load high");
      $display("test clear finished");
   endtask
   // A carry into the high byte between the two reads must not show.
   task automatic t_wide();
      wr(OFS_CONTROL, ctl(2'd0, 1'b1, 1'b0));
      setcount(8'h12, 8'hff);
      rchk(OFS_COUNT_LOW, 8'hff, "snap low");
      src_u.pulse(1);
      rchk(OFS_COUNT_HIGH, 8'h12, "snapped high");
      rchk(OFS_COUNT_LOW, 8'h00, "new low");
      rchk(OFS_COUNT_HIGH, 8'h13, "new high");
      $display("test wide finished");
   endtask
   task automatic t_ovf();
      wr(OFS_IRQ_MASK, 8'h00);
      setcount(8'hff, 8'hff);
      src_u.pulse(1);
      rchk(OFS_IRQ_STATUS, 8'h01, "wrap flag");
      `CHK(irq, 1'b0, "irq masked")
      wr(OFS_IRQ_MASK, 8'h01);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1, "irq raised")
      wr(OFS_IRQ_STATUS, 8'h01);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0, "irq cleared")
      rchk(OFS_IRQ_STATUS, 8'h00, "flag cleared");
      $display("test ovf finished");
   endtask
   // Count is loaded while frozen, so no write races an increment.
   task automatic t_sleep();
      sleep_mode <= 1'b1;
      wr(OFS_CONTROL, ctl(2'd0, 1'b0, 1'b0));
      setcount(8'hff, 8'hfe);
      src_u.pulse(2);
      rchk(OFS_COUNT_LOW, 8'hfe, "sync halts in sleep");
      wr(OFS_CONTROL, ctl(2'd0, 1'b0, 1'b1));
      src_u.pulse(2);
      rchk(OFS_COUNT_LOW, 8'h00, "async counts in sleep");
      `CHK(irq, 1'b1, "wake on wrap")
      rchk(OFS_COUNT_HIGH, 8'h00, "plain high read");
      sleep_mode <= 1'b0;
      rd(8'h40);
      `CHK(resp, RESP_SLVERR, "unmapped read")
      `CHK(data, 32'h0, "unmapped data")
      wr(8'h40, 8'h5a);
      `CHK(resp, RESP_SLVERR, "unmapped write")
      // A write with byte lane 0 off is answered but stores nothing.
      wstrb <= 4'he;
      wr(OFS_IRQ_MASK, 8'h00);
      `CHK(resp, RESP_OKAY, "lane off write")
      wstrb <= 4'hf;
      rchk(OFS_IRQ_MASK, 8'h01, "lane off keeps mask");
      $display("test sleep finished");
   endtask

   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Inputs settle at time zero; reset spans five edges.
   initial begin
      rst = 1'b1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      bready = 1'b0;
      rready = 1'b0;
      sleep_mode = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_osc();
      t_presc();
      t_clear();
      t_wide();
      t_ovf();
      t_sleep();
      end_of_test();
   end
endmodule
